// [core/msp_pkg.sv]
// Shared constants, types and helper functions of the meter serial port block.
package msp_pkg;

   // Clock and timing.
   localparam int unsigned MSP_CLK_HZ      = 20_000_000;
   localparam int unsigned MSP_TICK_PER_S  = 1000;
   localparam logic [7:0]  MSP_DELAY_MAX   = 8'hFA;

   // Baud rate choices, indexed by the baud select field.
   localparam logic [2:0]  MSP_BAUD_1200   = 3'h0;
   localparam logic [2:0]  MSP_BAUD_38400  = 3'h5;
   localparam int unsigned MSP_BAUD_TABLE [6] = '{1200, 2400, 4800, 9600, 19200, 38400};

   // Unit address limits and the address forced by the automatic USB setup.
   localparam logic [7:0]  MSP_ADDR_MODBUS_MAX = 8'hF7;
   localparam logic [7:0]  MSP_ADDR_VENDOR_MAX = 8'h63;
   localparam logic [7:0]  MSP_ADDR_USB_AUTO   = 8'hF7;
   localparam logic [7:0]  MSP_ADDR_NONE       = 8'h00;

   // Character framing: start plus data plus stop.
   localparam logic [3:0]  MSP_FRAME_BITS_8 = 4'hA;
   localparam logic [3:0]  MSP_FRAME_BITS_7 = 4'h9;

   // Print include flags: input, gross, tare, total, max and min, setpoints.
   localparam int          MSP_PRINT_ITEMS   = 6;
   localparam logic [5:0]  MSP_PRINT_DEFAULT = 6'h01;

   // Response FIFO geometry.
   localparam int          MSP_FIFO_WIDTH = 8;
   localparam int          MSP_FIFO_DEPTH = 16;

   // Communication type encodings.
   typedef enum logic [1:0] {
      MSP_COMM_VENDOR       = 2'h0,
      MSP_COMM_MODBUS_RTU   = 2'h1,
      MSP_COMM_MODBUS_ASCII = 2'h2
   } msp_comm_type;

   // Response sequencer states, Gray coded along idle, delay, shift.
   typedef enum logic [1:0] {
      MSP_ST_IDLE  = 2'h0,
      MSP_ST_DELAY = 2'h1,
      MSP_ST_SHIFT = 2'h3
   } msp_tx_state_type;

   // Stored port settings as programmed through the menus.
   typedef struct packed {
      logic         usb_auto_setup;
      msp_comm_type comm_type_setting;
      logic [2:0]   baud_sel;
      logic         bits8;
      logic [7:0]   addr;
      logic [7:0]   delay_ms;
      logic         abbrev;
      logic [5:0]   print_mask;
   } msp_cfg_type;

   // Settings in force on the active port.
   typedef struct packed {
      msp_comm_type proto;
      logic [2:0]   baud_sel;
      logic         bits8;
      logic [7:0]   addr;
   } msp_eff_type;

   // Clock cycles per bit for a given clock rate and baud select.
   function automatic logic [14:0] msp_baud_div(input int unsigned hz, input logic [2:0] sel);
      int unsigned rate;
      rate = MSP_BAUD_TABLE[(sel > MSP_BAUD_38400) ? MSP_BAUD_38400 : sel];
      return 15'(hz / rate);
   endfunction

   // Limits an address to the range that the protocol allows.
   function automatic logic [7:0] msp_clamp_addr(input logic [7:0] addr, input msp_comm_type proto);
      logic [7:0] lim;
      lim = (proto == MSP_COMM_VENDOR) ? MSP_ADDR_VENDOR_MAX : MSP_ADDR_MODBUS_MAX;
      return (addr > lim) ? lim : addr;
   endfunction

endpackage

// [core/msp_fifo.sv]
// Response byte FIFO with registered read data.
`timescale 1ns/1ps
`default_nettype none

module msp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic             i_clock,
   input  wire logic             i_sys_rst,
   // Filling side.
   input  wire logic             i_wr_valid,
   input  wire logic [WIDTH-1:0] i_wr_data,
   output logic                  o_wr_ready,
   // Draining side.
   output logic                  o_rd_valid,
   output logic [WIDTH-1:0]      o_rd_data,
   input  wire logic             i_rd_ready
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   typedef struct packed {
      logic [PW-1:0]    wr_ptr;
      logic [PW-1:0]    rd_ptr;
      logic [CW-1:0]    count;
      logic             out_valid;
      logic [WIDTH-1:0] out_data;
      logic             ready;
   } msp_fifo_state_type;

   msp_fifo_state_type q;
   msp_fifo_state_type d;
   logic [WIDTH-1:0]   mem [DEPTH];
   logic               push;
   logic               load;

   // The read word moves into an output register, so the array never drives a port directly.
   always_comb begin
      d    = q;
      push = i_wr_valid && q.ready;
      load = (!q.out_valid || i_rd_ready) && (q.count != '0);
      if (q.out_valid && i_rd_ready) begin
         d.out_valid = 1'b0;
      end
      if (load) begin
         d.out_valid = 1'b1;
         d.out_data  = mem[q.rd_ptr];
         d.rd_ptr    = q.rd_ptr + PW'(1);
      end
      if (push) begin
         d.wr_ptr = q.wr_ptr + PW'(1);
      end
      if (push && !load) begin
         d.count = q.count + CW'(1);
      end else if (load && !push) begin
         d.count = q.count - CW'(1);
      end
      // The output register holds one of the sixteen words, so it counts towards full.
      d.ready = ((d.count + CW'(d.out_valid)) != FULL);
   end

   // State register; ready is low during reset so nothing is lost.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Storage array; no reset needed since count guards every read.
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem[q.wr_ptr] <= i_wr_data;
      end
   end

   assign o_wr_ready = q.ready;
   assign o_rd_valid = q.out_valid;
   assign o_rd_data  = q.out_data;

endmodule

`default_nettype wire

// [core/msp_serial_port.sv]
// Meter serial port: port selection, effective settings, response delay and character transmitter.
`timescale 1ns/1ps
`default_nettype none

module msp_serial_port
   import msp_pkg::*;
#(
   parameter int unsigned CLOCK_HZ = MSP_CLK_HZ
) (
   // Clock and reset.
   input  wire logic         i_clock,
   input  wire logic         i_sys_rst,
   // Stored settings.
   input  wire msp_cfg_type  i_cfg,
   // Pins.
   input  wire logic         i_usb_attached,
   input  wire logic         i_card_present,
   input  wire logic         i_usb_rxd,
   input  wire logic         i_card_rxd,
   output logic              o_usb_txd,
   output logic              o_card_txd,
   // Events from the protocol engine.
   input  wire logic         i_cmd_done,
   input  wire logic         i_cmd_modbus,
   input  wire logic         i_print_req,
   // Response byte stream.
   input  wire logic         i_tx_valid,
   input  wire logic [7:0]   i_tx_data,
   output logic              o_tx_ready,
   // Status.
   output msp_eff_type       o_eff,
   output logic              o_rx_line,
   output logic              o_modbus_en,
   output logic              o_serial_menu_en,
   output logic              o_print_menu_en,
   output logic              o_print_block,
   output logic              o_send_addr,
   output logic              o_send_mnem,
   output logic [5:0]        o_print_mask,
   output logic              o_busy
);

   localparam int unsigned   MS_CYC_I = (CLOCK_HZ / MSP_TICK_PER_S < 1) ? 1 : CLOCK_HZ / MSP_TICK_PER_S;
   localparam logic [14:0]   MS_LAST  = 15'(MS_CYC_I - 1);

   typedef struct packed {
      logic [1:0]       usb_sync;
      logic [1:0]       card_sync;
      logic [1:0]       urx_sync;
      logic [1:0]       crx_sync;
      msp_tx_state_type st;
      logic [14:0]      pre;
      logic [7:0]       ms;
      logic [14:0]      div;
      logic [3:0]       bits;
      logic [9:0]       shreg;
      logic             usb_txd;
      logic             card_txd;
      logic             rx_line;
      msp_eff_type      eff;
      logic             modbus_en;
      logic             serial_menu_en;
      logic             print_menu_en;
      logic             print_block;
      logic             send_addr;
      logic             send_mnem;
      logic [5:0]       print_mask;
      logic             busy;
   } msp_port_state_type;

   msp_port_state_type q;
   msp_port_state_type d;
   logic               fifo_valid;
   logic [7:0]         fifo_data;
   logic               fifo_take;
   logic               usb_in_use;
   logic               card_open;
   logic               line;
   logic [14:0]        bit_div;

   // Response bytes queue here so the engine can run ahead of the slow serial line.
   msp_fifo #(
      .WIDTH (MSP_FIFO_WIDTH),
      .DEPTH (MSP_FIFO_DEPTH)
   ) u_fifo (
      .i_clock    (i_clock),
      .i_sys_rst  (i_sys_rst),
      .i_wr_valid (i_tx_valid),
      .i_wr_data  (i_tx_data),
      .o_wr_ready (o_tx_ready),
      .o_rd_valid (fifo_valid),
      .o_rd_data  (fifo_data),
      .i_rd_ready (fifo_take)
   );

   // The FIFO is drained only between characters, which back-pressures the engine.
   assign fifo_take = (q.st == MSP_ST_SHIFT) && (q.bits == '0);

   // Next-state logic for synchronisers, settings, sequencer and shifter.
   always_comb begin
      d          = q;
      d.usb_sync  = {q.usb_sync[0], i_usb_attached};
      d.card_sync = {q.card_sync[0], i_card_present};
      d.urx_sync  = {q.urx_sync[0], i_usb_rxd};
      d.crx_sync  = {q.crx_sync[0], i_card_rxd};
      usb_in_use = q.usb_sync[1];
      card_open  = q.card_sync[1] && !usb_in_use;

      // Forced values go to the effective set only; i_cfg is never overwritten.
      if (usb_in_use && i_cfg.usb_auto_setup) begin
         d.eff.proto    = MSP_COMM_MODBUS_RTU;
         d.eff.baud_sel = MSP_BAUD_38400;
         d.eff.bits8    = 1'b1;
         d.eff.addr     = MSP_ADDR_USB_AUTO;
      end else begin
         d.eff.proto    = i_cfg.comm_type_setting;
         d.eff.baud_sel = (i_cfg.baud_sel > MSP_BAUD_38400) ? MSP_BAUD_38400 : i_cfg.baud_sel;
         d.eff.bits8    = (i_cfg.comm_type_setting == MSP_COMM_MODBUS_RTU) || i_cfg.bits8;
         d.eff.addr     = msp_clamp_addr(i_cfg.addr, i_cfg.comm_type_setting);
      end
      d.modbus_en      = (d.eff.proto != MSP_COMM_VENDOR);
      d.serial_menu_en = q.card_sync[1];
      d.print_menu_en  = (i_cfg.comm_type_setting == MSP_COMM_VENDOR);
      d.send_mnem      = !i_cfg.abbrev;
      d.send_addr      = !i_cfg.abbrev && (d.eff.addr != MSP_ADDR_NONE);
      d.print_mask     = i_cfg.print_mask;
      d.print_block    = 1'b0;
      bit_div          = msp_baud_div(CLOCK_HZ, q.eff.baud_sel) - 15'(1);

      // Response sequencer.
      case (q.st)
         MSP_ST_IDLE: begin
            if (i_cmd_done && (i_cmd_modbus ? q.modbus_en : !q.modbus_en)) begin
               d.st  = MSP_ST_DELAY;
               d.ms  = (i_cfg.delay_ms > MSP_DELAY_MAX) ? MSP_DELAY_MAX : i_cfg.delay_ms;
               d.pre = '0;
            end else if (i_print_req && !q.modbus_en) begin
               d.st          = MSP_ST_SHIFT;
               d.print_block = 1'b1;
            end
         end
         MSP_ST_DELAY: begin
            if (q.ms == '0) begin
               d.st = MSP_ST_SHIFT;
            end else if (q.pre == MS_LAST) begin
               d.pre = '0;
               d.ms  = q.ms - 8'(1);
            end else begin
               d.pre = q.pre + 15'(1);
            end
         end
         MSP_ST_SHIFT: begin
            if (q.bits == '0) begin
               if (fifo_valid) begin
                  // Stop bit at the top, start bit at the bottom, LSB leaves first.
                  d.shreg = q.eff.bits8 ? {1'b1, fifo_data, 1'b0} : {2'b11, fifo_data[6:0], 1'b0};
                  d.bits  = q.eff.bits8 ? MSP_FRAME_BITS_8 : MSP_FRAME_BITS_7;
                  d.div   = bit_div;
               end else begin
                  d.st = MSP_ST_IDLE;
               end
            end else if (q.div == '0) begin
               d.shreg = {1'b1, q.shreg[9:1]};
               d.bits  = q.bits - 4'(1);
               d.div   = bit_div;
            end else begin
               d.div = q.div - 15'(1);
            end
         end
         default: begin
            d.st = MSP_ST_IDLE;
         end
      endcase

      // Only the port in use drives characters; the other idles at mark.
      line       = (d.bits != '0) ? d.shreg[0] : 1'b1;
      d.usb_txd  = usb_in_use ? line : 1'b1;
      d.card_txd = card_open ? line : 1'b1;
      d.rx_line  = usb_in_use ? q.urx_sync[1] : (card_open ? q.crx_sync[1] : 1'b1);
      d.busy     = (d.st != MSP_ST_IDLE);
   end

   // State register; lines idle at mark and the default print set applies after reset.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         q            <= '0;
         q.urx_sync   <= 2'h3;
         q.crx_sync   <= 2'h3;
         q.usb_txd    <= 1'b1;
         q.card_txd   <= 1'b1;
         q.rx_line    <= 1'b1;
         q.send_mnem  <= 1'b1;
         q.print_mask <= MSP_PRINT_DEFAULT;
         q.print_menu_en <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Every output but o_tx_ready, which the FIFO drives, comes from the state register.
   assign o_usb_txd        = q.usb_txd;
   assign o_card_txd       = q.card_txd;
   assign o_eff            = q.eff;
   assign o_rx_line        = q.rx_line;
   assign o_modbus_en      = q.modbus_en;
   assign o_serial_menu_en = q.serial_menu_en;
   assign o_print_menu_en  = q.print_menu_en;
   assign o_print_block    = q.print_block;
   assign o_send_addr      = q.send_addr;
   assign o_send_mnem      = q.send_mnem;
   assign o_print_mask     = q.print_mask;
   assign o_busy           = q.busy;

   // Helper logic for the delay check: cycles spent waiting and the delay that was loaded.
   logic [31:0] dly_cnt;
   logic [7:0]  dly_ms;
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || q.st != MSP_ST_DELAY) begin
         dly_cnt <= '0;
         dly_ms  <= d.ms;
      end else begin
         dly_cnt <= dly_cnt + 32'(1);
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   sequence s_load_char;
      (q.st == MSP_ST_SHIFT) && (q.bits == '0) && fifo_valid;
   endsequence

   sequence s_start_bit;
      (q.bits != '0) && !q.shreg[0] && (q.div == $past(bit_div));
   endsequence

   a_usb_auto_force: assert property ((q.usb_sync[1] && i_cfg.usb_auto_setup) |=>
      (o_eff.proto == MSP_COMM_MODBUS_RTU) && (o_eff.addr == MSP_ADDR_USB_AUTO) && (o_eff.baud_sel == MSP_BAUD_38400))
      else $error("Auto USB setup did not force the fixed settings.");
   a_serial_mode_use: assert property ((!q.usb_sync[1] && i_cfg.baud_sel <= MSP_BAUD_38400) |=>
      (o_eff.baud_sel == $past(i_cfg.baud_sel)) && (o_eff.proto == $past(i_cfg.comm_type_setting)))
      else $error("Serial mode did not use the programmed settings.");
   a_rtu_eight_bits: assert property ((o_eff.proto == MSP_COMM_MODBUS_RTU) |-> o_eff.bits8)
      else $error("Modbus RTU without 8 data bits.");
   a_addr_limit: assert property ((o_eff.proto == MSP_COMM_VENDOR) |-> (o_eff.addr <= MSP_ADDR_VENDOR_MAX))
      else $error("Vendor protocol address above its limit.");
   a_delay_least: assert property (((q.st == MSP_ST_DELAY) && (d.st == MSP_ST_SHIFT)) |->
      (dly_cnt >= 32'(dly_ms) * MS_CYC_I))
      else $error("Response started before the programmed delay.");
   a_full_format: assert property (o_send_addr |-> (o_send_mnem && o_eff.addr != MSP_ADDR_NONE))
      else $error("Address sent while abbreviated or zero.");
   a_card_muted: assert property (q.usb_sync[1] |=> (o_card_txd && o_rx_line == $past(q.urx_sync[1])))
      else $error("Option card active while USB in use.");
   a_modbus_gate: assert property ((o_eff.proto == MSP_COMM_VENDOR) |-> !o_modbus_en)
      else $error("Modbus enabled under vendor protocol.");
   a_print_vendor: assert property ($rose(o_print_block) |-> (!o_modbus_en && o_busy))
      else $error("Print block outside vendor protocol.");
   a_frame_start: assert property (s_load_char |=> s_start_bit ##1 (q.bits != '0))
      else $error("Character did not open with a start bit.");

   // The lines rest at mark outside frames, and the sequencer moves only on requests it may accept.
   a_idle_mark: assert property ((q.st == MSP_ST_IDLE) |-> (o_usb_txd && o_card_txd))
      else $error("Transmit line left mark while idle.");
   a_delay_quiet: assert property ((q.st == MSP_ST_DELAY) |-> (o_usb_txd && o_card_txd))
      else $error("Transmit line active during the response delay.");
   a_cmd_accept: assert property (((q.st == MSP_ST_IDLE) && i_cmd_done && (i_cmd_modbus == q.modbus_en)) |=>
      ((q.st == MSP_ST_DELAY) && o_busy))
      else $error("Matching command did not start the response delay.");
   a_cmd_gate: assert property (((q.st == MSP_ST_IDLE) && i_cmd_done && !i_print_req &&
      (i_cmd_modbus != q.modbus_en)) |=> (q.st == MSP_ST_IDLE))
      else $error("Command of the wrong protocol was accepted.");
   a_print_start: assert property (((q.st == MSP_ST_IDLE) && !q.modbus_en && i_print_req && !i_cmd_done) |=>
      ((q.st == MSP_ST_SHIFT) && o_print_block))
      else $error("Print request did not start a block without delay.");
   a_menu_card: assert property (!q.card_sync[1] |=> !o_serial_menu_en)
      else $error("Serial port menu offered without an option card.");
   a_rx_mark: assert property ((!q.usb_sync[1] && !q.card_sync[1]) |=> o_rx_line)
      else $error("Receive line not at mark with no port open.");

endmodule

`default_nettype wire

// [dv/msp_host_model.sv]
// Behavioural host that decodes characters from one transmit line of the meter.
`timescale 1ns/1ps
`default_nettype none

module msp_host_model (
   // Clock and line.
   input  wire logic        i_clock,
   input  wire logic        i_line,
   // Link settings agreed with the meter.
   input  wire logic [15:0] i_div,
   input  wire logic        i_bits8,
   // Decoded character: framing good in bit 8.
   output logic             o_valid,
   output logic [8:0]       o_char
);
   int   k;
   logic ok;

   // Sample each bit at its centre, so a stop bit that runs one cycle long is harmless.
   initial begin
      o_valid = 1'b0;
      o_char  = 9'h000;
      forever begin
         @(negedge i_line);
         repeat (i_div / 2) @(posedge i_clock);
         ok = ~i_line;
         o_char = 9'h000;
         for (k = 0; k < (i_bits8 ? 8 : 7); k++) begin
            repeat (i_div) @(posedge i_clock);
            o_char[k] = i_line;
         end
         repeat (i_div) @(posedge i_clock);
         o_char[8] = ok & i_line;
         o_valid = 1'b1;
         @(negedge i_clock);
         o_valid = 1'b0;
      end
   end
endmodule

`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the meter serial port with a host on each port.
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import msp_pkg::*;
;
   localparam int unsigned CHZ = 200000;
   logic i_clock, i_sys_rst, usb_att, card_pr, usb_rxd, card_rxd, cmd_done, cmd_mb, print_req, tx_valid;
   logic usb_txd, card_txd, tx_ready, rx_line, mb_en, ser_men, pr_men, pr_blk, s_addr, s_mnem, busy;
   logic uv, cv, b;
   logic [7:0] tx_data, a, lim;
   logic [5:0] pmask;
   logic [8:0] uch, cch;
   logic [9:0] e;
   logic [9:0] exp_q[$];
   msp_cfg_type cfg;
   msp_eff_type eff;
   msp_comm_type ct;
   int failures, checks, seed, n, i, t;

   // Free-running clock, 50 ns period.
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   msp_serial_port #(.CLOCK_HZ(CHZ)) dut (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cfg(cfg),
      .i_usb_attached(usb_att), .i_card_present(card_pr), .i_usb_rxd(usb_rxd), .i_card_rxd(card_rxd),
      .o_usb_txd(usb_txd), .o_card_txd(card_txd), .i_cmd_done(cmd_done), .i_cmd_modbus(cmd_mb),
      .i_print_req(print_req), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
      .o_eff(eff), .o_rx_line(rx_line), .o_modbus_en(mb_en), .o_serial_menu_en(ser_men),
      .o_print_menu_en(pr_men), .o_print_block(pr_blk), .o_send_addr(s_addr), .o_send_mnem(s_mnem),
      .o_print_mask(pmask), .o_busy(busy));
   msp_host_model host_usb (.i_clock(i_clock), .i_line(usb_txd), .i_div(16'h0005), .i_bits8(b),
      .o_valid(uv), .o_char(uch));
   msp_host_model host_card (.i_clock(i_clock), .i_line(card_txd), .i_div(16'h0005), .i_bits8(b),
      .o_valid(cv), .o_char(cch));

   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      checks++;
      if (seen !== expv) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask

   task automatic end_sim();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cyc(input int c);
      repeat (c) @(negedge i_clock);
   endtask

   task automatic pulse_cmd(input logic m);
      cmd_mb = m;
      cmd_done = 1'b1;
      cyc(1);
      cmd_done = 1'b0;
   endtask

   // Ready is registered, so its value at the falling edge is the one sampled next.
   task automatic put(input logic [7:0] d, input logic p);
      tx_data = d;
      tx_valid = 1'b1;
      n = 0;
      while (tx_ready !== 1'b1 && n < 50) begin
         cyc(1);
         n++;
      end
      if (n == 50) begin
         failures++;
         end_sim();
      end
      cyc(1);
      exp_q.push_back({p, 1'b1, b ? d : {1'b0, d[6:0]}});
   endtask

   task automatic wait_idle();
      n = 0;
      while ((busy !== 1'b0 || exp_q.size() != 0) && n < 20000) begin
         cyc(1);
         n++;
      end
      if (n == 20000) begin
         failures++;
         end_sim();
      end
   endtask

   // Every decoded character retires the oldest note; the port bit catches a muted card talking.
   always @(posedge uv or posedge cv) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3FF;
      chk(cv ? {1'b1, cch} : {1'b0, uch}, e);
   end

   // Watchdog against a hung run.
   initial begin
      repeat (100000) @(posedge i_clock);
      failures++;
      end_sim();
   end

   // Main sequence.
   initial begin
      seed = 32'hAA032FEC;
      failures = 0;
      checks = 0;
      {i_sys_rst, usb_rxd, card_rxd, b} = 4'hF;
      {usb_att, card_pr, cmd_done, cmd_mb, print_req, tx_valid, tx_data} = 14'h0000;
      cfg = '{1'b1, MSP_COMM_VENDOR, 3'h5, 1'b1, 8'h05, 8'h00, 1'b0, MSP_PRINT_DEFAULT};
      cyc(8);
      chk(pmask, 6'h01);
      chk({s_mnem, pr_men, busy, usb_txd, card_txd}, 5'h1B);
      i_sys_rst = 1'b0;
      cyc(4);
      chk({ser_men, rx_line}, 2'h1);
      $display("test reset done");
      card_pr = 1'b1;
      for (t = 0; t < 3; t++) begin
         for (i = 0; i < 8; i++) begin
            ct = msp_comm_type'(t);
            a = 8'($random(seed));
            b = 1'($random(seed));
            cfg = '{1'b0, ct, 3'(i), b, a, 8'h00, 1'b0, MSP_PRINT_DEFAULT};
            usb_rxd = 1'($random(seed));
            card_rxd = 1'($random(seed));
            cyc(4);
            lim = (ct == MSP_COMM_VENDOR) ? 8'h63 : 8'hF7;
            chk(eff, msp_eff_type'{ct, (i > 5) ? 3'h5 : 3'(i), b | (ct == MSP_COMM_MODBUS_RTU), (a > lim) ? lim : a});
            chk(mb_en, ct != MSP_COMM_VENDOR);
            chk(pr_men, ct == MSP_COMM_VENDOR);
            chk({ser_men, rx_line}, {1'b1, card_rxd});
         end
      end
      $display("test settings done");
      cfg = '{1'b1, MSP_COMM_VENDOR, 3'h0, 1'b0, 8'h05, 8'h00, 1'b0, MSP_PRINT_DEFAULT};
      usb_att = 1'b1;
      cyc(4);
      chk(eff, msp_eff_type'{MSP_COMM_MODBUS_RTU, 3'h5, 1'b1, 8'hF7});
      chk(pr_men, 1'b1);
      chk(rx_line, usb_rxd);
      b = 1'b1;
      for (i = 0; i < 3; i++)
         put(8'($random(seed)), 1'b0);
      tx_valid = 1'b0;
      pulse_cmd(1'b1);
      wait_idle();
      cfg.usb_auto_setup = 1'b0;
      cyc(4);
      chk(eff, msp_eff_type'{MSP_COMM_VENDOR, 3'h0, 1'b0, 8'h05});
      $display("test usb done");
      usb_att = 1'b0;
      cfg = '{1'b0, MSP_COMM_VENDOR, 3'h5, 1'b0, 8'h05, 8'h00, 1'b0, 6'(MSP_PRINT_DEFAULT)};
      cyc(4);
      chk({s_addr, s_mnem}, 2'h3);
      cfg.abbrev = 1'b1;
      cfg.print_mask = 6'($random(seed));
      cyc(2);
      chk({s_addr, s_mnem, pmask}, {2'h0, cfg.print_mask});
      cfg.abbrev = 1'b0;
      cfg.addr = 8'h00;
      cyc(2);
      chk({s_addr, s_mnem}, 2'h1);
      b = 1'b0;
      put(8'hA5, 1'b1);
      put(8'h3C, 1'b1);
      tx_valid = 1'b0;
      print_req = 1'b1;
      t = 0;
      for (i = 0; i < 4; i++) begin
         cyc(1);
         print_req = 1'b0;
         t += int'(pr_blk);
      end
      chk(t, 1);
      wait_idle();
      $display("test print done");
      pulse_cmd(1'b1);
      cyc(2);
      chk(busy, 1'b0);
      cfg.delay_ms = 8'h01;
      b = 1'b1;
      cfg.bits8 = 1'b1;
      cyc(2);
      put(8'h5A, 1'b1);
      tx_valid = 1'b0;
      pulse_cmd(1'b0);
      n = 0;
      while (card_txd !== 1'b0 && n < 1000) begin
         cyc(1);
         n++;
      end
      chk(n >= 200 && n < 1000, 1'b1);
      if (n == 1000) begin
         end_sim();
      end
      wait_idle();
      $display("test delay done");
      cfg.delay_ms = 8'h00;
      for (i = 0; i < 16; i++)
         put(8'(i * 17), 1'b1);
      cyc(2);
      chk(tx_ready, 1'b0);
      tx_valid = 1'b0;
      pulse_cmd(1'b0);
      wait_idle();
      chk(tx_ready, 1'b1);
      $display("test fifo done");
      end_sim();
   end
endmodule

`default_nettype wire
